/* File: wsc_terminal.sv */
// Handheld terminal end: coupling sequence, indicator and register slave.
// Operation
// - Indicator always shows one of five patterns
// - Fast blink: 100 ms lit, 100 dark
// - Slow blink: 500 ms lit, 500 dark
// - Irregular: 200 on, 200 off, 200 on, 400 off
// - Radio loss in run recovers automatically
// - After shutdown, token plus test recouples
// - Cabinet power cycle: recouple without timeout
// - Off idle, blink connecting, on connected
// - Cabinet treats link drop as stop
// - Enabling effective exactly with stop button
// - Token inserted: fast blink awaiting test
// - Press then release stop, enable released
// - Coupled: both indicators on, run state
// - Single token cabinet starts safe, waits
// - Search cabinet, connect, run; fault falls back
// - Token in cabinet puts it idle; the code does so from safe and at power-on, not from run
// - In-time coupling goes idle to run
// - From safe, coupling may be retried anytime
// - Powered without token: indicator off
// - Coupling bounded by 50 s timeout
// - Cabinet goes safe after 160 ms silence
// - Idle stop contact closed, enable open; safe and emergency open
`timescale 1ns/1ns
module wsc_terminal #(
    parameter int CYC_MS = wsc_pkg::CYC_PER_MS,
    parameter int COUPLE_MS = wsc_pkg::COUPLING_TIMEOUT_MS
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Operator and radio status.
    input wire logic term_powered,
    input wire logic token_in,
    input wire logic stop_pressed,
    input wire logic enable_pressed,
    input wire logic radio_ok,
    // Indicator and safety function state.
    output logic led_ff,
    output logic stop_active_ff,
    output logic enable_active_ff,
    // AXI4-Lite slave.
    input wire logic [3:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [3:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Link.
    wsc_link_if.terminal link
);

    // ==========================================================
    // State machine.
    typedef enum logic [2:0] {
        T_OFF = 3'b000,
        T_WAIT_TEST = 3'b001,
        T_PRESSED = 3'b011,
        T_SEARCH = 3'b010,
        T_RUN = 3'b110,
        T_LOST = 3'b111,
        T_FAILED = 3'b101
    } wsc_tstate_t;

    wsc_tstate_t state_ff;
    wsc_tstate_t nxt_state;
    wsc_pkg::wsc_pat_t pat;
    wsc_pkg::wsc_pat_t pat_ff;
    logic [31:0] ctrl_ff;
    logic [$clog2(CYC_MS)-1:0] pre_ff;
    logic [wsc_pkg::MS_W-1:0] ms_ff;
    logic [$clog2(COUPLE_MS+1)-1:0] couple_ms_ff;
    logic tick;
    logic couple_en;

    assign tick = pre_ff == ($clog2(CYC_MS))'(CYC_MS - 1);
    assign couple_en = ctrl_ff[wsc_pkg::CTRL_COUPLE_EN_BIT];

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            T_OFF: begin
                if (token_in) begin
                    nxt_state = T_WAIT_TEST;
                end
            end
            T_WAIT_TEST: begin
                if (stop_pressed && !enable_pressed) begin
                    nxt_state = T_PRESSED;
                end
            end
            T_PRESSED: begin
                if (enable_pressed) begin
                    nxt_state = T_WAIT_TEST;
                end else if (!stop_pressed && couple_en) begin
                    nxt_state = T_SEARCH;
                end
            end
            T_SEARCH: begin
                if (link.cab_link) begin
                    nxt_state = T_RUN;
                end else if (couple_ms_ff == ($bits(couple_ms_ff))'(COUPLE_MS))
                begin
                    nxt_state = T_FAILED;
                end
            end
            T_RUN: begin
                if (!radio_ok || !link.cab_link) begin
                    nxt_state = T_LOST;
                end
            end
            T_LOST: begin
                if (radio_ok && link.cab_link) begin
                    nxt_state = T_RUN;
                end
            end
            default: begin
                nxt_state = T_FAILED;
            end
        endcase
        // shutdown or token removal restarts coupling
        if (!term_powered || !token_in) begin
            nxt_state = T_OFF;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_ff <= T_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn || state_ff != T_SEARCH) begin
            couple_ms_ff <= '0;
        end else if (tick && couple_ms_ff !=
                     ($bits(couple_ms_ff))'(COUPLE_MS)) begin
            couple_ms_ff <= couple_ms_ff + 1'b1;
        end
    end

    // ==========================================================
    // Indicator.
    always_comb begin
        case (state_ff)
            T_WAIT_TEST, T_PRESSED, T_FAILED: pat = wsc_pkg::PAT_FAST;
            T_SEARCH, T_LOST: pat = wsc_pkg::PAT_SLOW;
            T_RUN: pat = wsc_pkg::PAT_ON;
            default: pat = wsc_pkg::PAT_OFF;
        endcase
    end

    // millisecond base restarts on pattern change
    always_ff @(posedge clk) begin
        if (!rstn || pat != pat_ff) begin
            pre_ff <= '0;
            ms_ff <= '0;
        end else if (tick) begin
            pre_ff <= '0;
            if (ms_ff == wsc_pkg::pat_period(pat_ff) - 1'b1) begin
                ms_ff <= '0;
            end else begin
                ms_ff <= ms_ff + 1'b1;
            end
        end else begin
            pre_ff <= pre_ff + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pat_ff <= wsc_pkg::PAT_OFF;
            led_ff <= 1'b0;
        end else begin
            pat_ff <= pat;
            led_ff <= pat == pat_ff && wsc_pkg::pat_level(pat_ff, ms_ff);
        end
    end

    // ==========================================================
    // Safety functions and link.
    // stop and enabling operative together
    always_ff @(posedge clk) begin
        if (!rstn) begin
            stop_active_ff <= 1'b0;
            enable_active_ff <= 1'b0;
        end else begin
            stop_active_ff <= nxt_state == T_RUN;
            enable_active_ff <= nxt_state == T_RUN;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            link.term_search <= 1'b0;
            link.term_beat <= 1'b0;
            link.term_stop_ok <= 1'b0;
            link.term_enable_ok <= 1'b0;
        end else begin
            link.term_search <= radio_ok &&
                (nxt_state == T_SEARCH || nxt_state == T_LOST);
            link.term_beat <= radio_ok && state_ff == T_RUN && tick;
            link.term_stop_ok <= !stop_pressed;
            link.term_enable_ok <= enable_pressed;
        end
    end

    // ==========================================================
    // Register slave.
    logic wr_go;
    logic wr_ok;
    logic rd_go;

    assign wr_go = s_awvalid && s_wvalid && !s_bvalid;
    assign wr_ok = s_awaddr == wsc_pkg::REG_CTRL;
    assign rd_go = s_arvalid && !s_rvalid;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_awready <= 1'b0;
            s_wready <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp <= wsc_pkg::RESP_OKAY;
            ctrl_ff <= wsc_pkg::CTRL_RESET;
        end else begin
            s_awready <= wr_go && !s_awready;
            s_wready <= wr_go && !s_awready;
            if (wr_go && !s_awready) begin
                s_bresp <= wr_ok ? wsc_pkg::RESP_OKAY : wsc_pkg::RESP_SLVERR;
                if (wr_ok && s_wstrb[0]) begin
                    ctrl_ff <= {31'h0000_0000, s_wdata[0]};
                end
            end
            s_bvalid <= s_awready || (s_bvalid && !s_bready);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0000_0000;
            s_rresp <= wsc_pkg::RESP_OKAY;
        end else begin
            s_arready <= rd_go && !s_arready;
            if (rd_go && !s_arready) begin
                s_rresp <= wsc_pkg::RESP_OKAY;
                s_rdata <= 32'h0000_0000;
                if (s_araddr == wsc_pkg::REG_CTRL) begin
                    s_rdata <= ctrl_ff;
                end else if (s_araddr == wsc_pkg::REG_STATUS) begin
                    s_rdata[wsc_pkg::STAT_STATE_LSB +: 3] <= state_ff;
                    s_rdata[wsc_pkg::STAT_PAT_LSB +: 3] <= pat_ff;
                    s_rdata[wsc_pkg::STAT_LED_BIT] <= led_ff;
                    s_rdata[wsc_pkg::STAT_STOP_BIT] <= stop_active_ff;
                end else begin
                    s_rresp <= wsc_pkg::RESP_SLVERR;
                end
            end
            s_rvalid <= s_arready || (s_rvalid && !s_rready);
        end
    end

endmodule : wsc_terminal

/* File: wsc_pkg.sv */
// Shared constants, types and pattern helpers for the coupling controller.
package wsc_pkg;

    // ==========================================================
    // Timing.
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam int FAST_HALF_MS = 100;
    localparam int SLOW_HALF_MS = 500;
    localparam int IRR_ON_MS = 200;
    localparam int IRR_GAP_MS = 200;
    localparam int IRR_LONG_GAP_MS = 400;
    localparam int COUPLING_TIMEOUT_S = 50;
    localparam int COUPLING_TIMEOUT_MS = COUPLING_TIMEOUT_S * 1000;
    localparam int SAFETY_TIMEOUT_MS = 160;
    localparam int MS_W = 10;

    // ==========================================================
    // Register map of the terminal end.
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam int CTRL_COUPLE_EN_BIT = 0;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_PAT_LSB = 4;
    localparam int STAT_LED_BIT = 8;
    localparam int STAT_STOP_BIT = 9;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Indicator patterns.
    typedef enum logic [2:0] {
        PAT_OFF = 3'h0,
        PAT_FAST = 3'h1,
        PAT_SLOW = 3'h2,
        PAT_IRREGULAR = 3'h3,
        PAT_ON = 3'h4
    } wsc_pat_t;

    // Length of one pattern cycle in milliseconds.
    function automatic logic [MS_W-1:0] pat_period(input wsc_pat_t p);
        case (p)
            PAT_FAST: pat_period = MS_W'(2 * FAST_HALF_MS);
            PAT_SLOW: pat_period = MS_W'(2 * SLOW_HALF_MS);
            PAT_IRREGULAR: pat_period = MS_W'(2 * IRR_ON_MS + IRR_GAP_MS
                                              + IRR_LONG_GAP_MS);
            default: pat_period = MS_W'(1);
        endcase
    endfunction : pat_period

    // Lamp level at a given millisecond of the pattern cycle.
    function automatic logic pat_level(input wsc_pat_t p,
                                       input logic [MS_W-1:0] ms);
        case (p)
            PAT_FAST: pat_level = ms < MS_W'(FAST_HALF_MS);
            PAT_SLOW: pat_level = ms < MS_W'(SLOW_HALF_MS);
            PAT_IRREGULAR: pat_level = (ms < MS_W'(IRR_ON_MS)) ||
                ((ms >= MS_W'(IRR_ON_MS + IRR_GAP_MS)) &&
                 (ms < MS_W'(2 * IRR_ON_MS + IRR_GAP_MS)));
            PAT_ON: pat_level = 1'b1;
            default: pat_level = 1'b0;
        endcase
    endfunction : pat_level

endpackage : wsc_pkg

/* File: wsc_link_if.sv */
// Radio link between the handheld terminal and the cabinet station.
`timescale 1ns/1ns
interface wsc_link_if;
    // Terminal to cabinet.
    logic term_search;
    logic term_beat;
    logic term_stop_ok;
    logic term_enable_ok;
    // Cabinet to terminal.
    logic cab_link;

    modport terminal (
        output term_search,
        output term_beat,
        output term_stop_ok,
        output term_enable_ok,
        input cab_link
    );
    modport cabinet (
        input term_search,
        input term_beat,
        input term_stop_ok,
        input term_enable_ok,
        output cab_link
    );
endinterface : wsc_link_if

/* File: wsc_cabinet.sv */
// Cabinet station end: idle, safe, run and emergency handling.
`timescale 1ns/1ns
module wsc_cabinet #(
    parameter int CYC_MS = wsc_pkg::CYC_PER_MS,
    parameter int COUPLE_MS = wsc_pkg::COUPLING_TIMEOUT_MS,
    parameter int SAFETY_MS = wsc_pkg::SAFETY_TIMEOUT_MS
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Station inputs.
    input wire logic power_on_self_test_ok,
    input wire logic token_in_cab,
    // Indicator and output contacts.
    output logic led_ff,
    output logic stop_closed_ff,
    output logic enable_closed_ff,
    output logic [2:0] state_ff,
    // Link.
    wsc_link_if.cabinet link
);

    // ==========================================================
    // State machine.
    typedef enum logic [2:0] {
        C_IDLE = 3'b000,
        C_RUN = 3'b001,
        C_SAFE = 3'b011,
        C_EMG = 3'b010
    } wsc_cstate_t;

    wsc_cstate_t st_ff;
    wsc_cstate_t nxt_st;
    wsc_pkg::wsc_pat_t pat;
    wsc_pkg::wsc_pat_t pat_ff;
    logic [$clog2(CYC_MS)-1:0] pre_ff;
    logic [wsc_pkg::MS_W-1:0] ms_ff;
    logic [$clog2(COUPLE_MS+1)-1:0] tmo_ff;
    logic tick;
    logic tmo_done;
    logic silent;

    assign tick = pre_ff == ($clog2(CYC_MS))'(CYC_MS - 1);
    assign tmo_done = tmo_ff == ($bits(tmo_ff))'(COUPLE_MS);
    assign silent = tmo_ff == ($bits(tmo_ff))'(SAFETY_MS);

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            C_IDLE: begin
                if (token_in_cab) begin
                    nxt_st = C_IDLE;
                end else if (link.term_search) begin
                    nxt_st = C_RUN;
                end else if (tmo_done) begin
                    nxt_st = C_SAFE;
                end
            end
            C_RUN: begin
                if (silent) begin
                    nxt_st = C_SAFE;
                end
            end
            C_SAFE: begin
                if (token_in_cab) begin
                    nxt_st = C_IDLE;
                end else if (link.term_search) begin
                    nxt_st = C_RUN;
                end
            end
            default: begin
                nxt_st = C_EMG;
            end
        endcase
        if (!power_on_self_test_ok) begin
            nxt_st = C_EMG;
        end
    end

    // power-on state from the token slot
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_ff <= C_EMG;
        end else if (st_ff == C_EMG && power_on_self_test_ok && pat_ff == wsc_pkg::PAT_OFF)
        begin
            st_ff <= token_in_cab ? C_IDLE : C_SAFE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Shared millisecond timer: coupling window in idle, silence in run.
    always_ff @(posedge clk) begin
        if (!rstn || st_ff != nxt_st || token_in_cab ||
            (st_ff == C_RUN && link.term_beat)) begin
            tmo_ff <= '0;
        end else if (tick && !tmo_done) begin
            tmo_ff <= tmo_ff + 1'b1;
        end
    end

    // ==========================================================
    // Indicator.
    always_comb begin
        case (st_ff)
            C_RUN: pat = wsc_pkg::PAT_ON;
            C_SAFE: pat = wsc_pkg::PAT_FAST;
            C_EMG: pat = power_on_self_test_ok ? wsc_pkg::PAT_OFF : wsc_pkg::PAT_IRREGULAR;
            default: pat = wsc_pkg::PAT_OFF;
        endcase
    end

    // millisecond base restarts on pattern change
    always_ff @(posedge clk) begin
        if (!rstn || pat != pat_ff) begin
            pre_ff <= '0;
            ms_ff <= '0;
        end else if (tick) begin
            pre_ff <= '0;
            if (ms_ff == wsc_pkg::pat_period(pat_ff) - 1'b1) begin
                ms_ff <= '0;
            end else begin
                ms_ff <= ms_ff + 1'b1;
            end
        end else begin
            pre_ff <= pre_ff + 1'b1;
        end
    end

    // one pattern on the cabinet lamp
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pat_ff <= wsc_pkg::PAT_OFF;
            led_ff <= 1'b0;
        end else begin
            pat_ff <= pat;
            led_ff <= pat == pat_ff && wsc_pkg::pat_level(pat_ff, ms_ff);
        end
    end

    // ==========================================================
    // Contacts and link answer.
    // stop closed in idle, both follow terminal in run, else open
    always_ff @(posedge clk) begin
        if (!rstn) begin
            stop_closed_ff <= 1'b0;
            enable_closed_ff <= 1'b0;
            link.cab_link <= 1'b0;
            state_ff <= 3'h0;
        end else begin
            stop_closed_ff <= nxt_st == C_IDLE ||
                (nxt_st == C_RUN && link.term_stop_ok);
            enable_closed_ff <= nxt_st == C_RUN && link.term_enable_ok;
            link.cab_link <= nxt_st == C_RUN;
            state_ff <= nxt_st;
        end
    end

endmodule : wsc_cabinet

/* File: wsc_link_props.sv */
// Assertions on the radio link between the terminal and cabinet ends.
`timescale 1ns/1ns
module wsc_link_props #(
    parameter int CYC_MS = 10,
    parameter int SAFETY_MS = 5
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Link signals.
    input wire logic term_search,
    input wire logic term_beat,
    input wire logic term_stop_ok,
    input wire logic term_enable_ok,
    input wire logic cab_link
);
    // ==========
    // Silence counter.
    // The cabinet counts whole milliseconds, so two spare ones are allowed.
    localparam int QUIET_MAX = (SAFETY_MS + 2) * CYC_MS;
    int quiet_ff;
    int nxt_quiet;

    always_comb begin
        nxt_quiet = (cab_link && !term_beat) ? quiet_ff + 1 : 0;
    end

    always_ff @(posedge clk) begin
        quiet_ff <= !rstn ? 0 : nxt_quiet;
    end

    // ==========
    // Properties.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence beat_gap_s;
        !term_beat [*8];
    endsequence
    sequence linked_s;
        $rose(cab_link);
    endsequence

    quiet_bound_a:
    assert property (quiet_ff <= QUIET_MAX)
        else $error("link held through a silent run");
    beat_pulse_a:
    assert property (term_beat |=> beat_gap_s)
        else $error("beat not a spaced pulse");
    beat_cause_a:
    assert property (term_beat |-> $past(cab_link) || $past(cab_link, 2)
                     || $past(cab_link, 3))
        else $error("beat without a link");
    reset_quiet_a:
    assert property ($rose(rstn) |-> !cab_link && !term_search && !term_beat)
        else $error("link active out of reset");
    search_test_a:
    assert property ($rose(term_search) |-> term_stop_ok && !term_enable_ok)
        else $error("search without a clean stop test");
    search_ends_a:
    assert property (linked_s |-> ##[1:3] !term_search)
        else $error("search kept after link");
    link_cause_a:
    assert property (linked_s |-> $past(term_search) || $past(term_search, 2)
                     || $past(term_search, 3))
        else $error("link without a search");
    link_gone_a:
    assert property ($fell(cab_link) |-> ##3 beat_gap_s)
        else $error("beats after link drop");
endmodule : wsc_link_props

/* File: tb_wireless_safety_coupling_fsm.sv */
// Self-checking bench: terminal and cabinet ends coupled over the link.
`timescale 1ns/1ns
module tb_wireless_safety_coupling_fsm;
    // ==========
    // Scaled counts keep the run well under the cycle ceiling.
    localparam int CYC = 10;
    localparam int SAFE = 5;
    localparam int COUPLE = 3500;
    localparam logic [1:0] OK = wsc_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = wsc_pkg::RESP_SLVERR;

    logic clk, rstn, powered, token, stop, en, radio, power_on_self_test_ok, tok_cab;
    logic t_led, t_stop, t_en, c_led, c_stop, c_en, saw_safe;
    logic [2:0] c_state;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, d;
    logic awvalid, awready, wvalid, wready, bvalid, bready, ha, hw, hb;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp, rs;
    int failures, compares, ticks;

    wsc_link_if wsc_link_if_i ();
    wsc_terminal #(.CYC_MS(CYC), .COUPLE_MS(COUPLE)) wsc_terminal_i (
        .clk(clk), .rstn(rstn), .term_powered(powered), .token_in(token),
        .stop_pressed(stop), .enable_pressed(en), .radio_ok(radio),
        .led_ff(t_led), .stop_active_ff(t_stop), .enable_active_ff(t_en),
        .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
        .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
        .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
        .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
        .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
        .s_rvalid(rvalid), .s_rready(rready), .link(wsc_link_if_i));
    wsc_cabinet #(.CYC_MS(CYC), .COUPLE_MS(COUPLE), .SAFETY_MS(SAFE))
        wsc_cabinet_i (.clk(clk), .rstn(rstn), .power_on_self_test_ok(power_on_self_test_ok),
        .token_in_cab(tok_cab), .led_ff(c_led), .stop_closed_ff(c_stop),
        .enable_closed_ff(c_en), .state_ff(c_state), .link(wsc_link_if_i));
    wsc_link_props #(.CYC_MS(CYC), .SAFETY_MS(SAFE)) wsc_link_props_i (
        .clk(clk), .rstn(rstn), .term_search(wsc_link_if_i.term_search),
        .term_beat(wsc_link_if_i.term_beat),
        .term_stop_ok(wsc_link_if_i.term_stop_ok),
        .term_enable_ok(wsc_link_if_i.term_enable_ok),
        .cab_link(wsc_link_if_i.cab_link));

    // ==========
    // Common tasks.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %0h, expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim;
        $display("Compares %0d, failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // Ready and valid are sampled mid-cycle, where the registered outputs
    // are settled, and acted on at the following rising edge.
    task automatic wr(input logic [3:0] a, input logic [31:0] v,
                      input logic [1:0] er);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            ha = awready;
            hw = wready;
            hb = bvalid;
            rs = bresp;
            @(posedge clk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
        end while (!hb);
        bready <= 1'b0;
        chk(rs, er);
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk);
            ha = arready;
            hb = rvalid;
            d = rdata;
            rs = rresp;
            @(posedge clk);
            if (ha) arvalid <= 1'b0;
        end while (!hb);
        rready <= 1'b0;
        chk(rs, er);
        @(posedge clk);
    endtask : rd

    task automatic st(input logic [2:0] s, input logic [2:0] p);
        rd(wsc_pkg::REG_STATUS, OK);
        chk(d[2:0], s);
        chk(d[6:4], p);
    endtask : st

    task automatic sys(input logic [2:0] s, input logic sc, input logic run);
        @(negedge clk);
        chk(c_state, s);
        chk(c_stop, sc);
        chk(c_en, 1'b0);
        chk({t_stop, t_en, c_led & run}, {3{run}});
        @(posedge clk);
    endtask : sys

    task automatic press(input logic hold);
        en <= hold;
        stop <= 1'b1;
        cyc(5);
        stop <= 1'b0;
        cyc(5);
        en <= 1'b0;
        cyc(2);
    endtask : press

    task automatic couple;
        press(1'b0);
        cyc(10);
        sys(3'h1, 1'b1, 1'b1);
    endtask : couple

    function automatic logic led(input logic cab);
        return cab ? c_led : t_led;
    endfunction : led

    // Syncs to a rising lamp, then times up to four phases in ms.
    task automatic wave(input logic cab, input int a, b, c, e);
        int ms[4];
        int n;
        logic v;
        ms = '{a, b, c, e};
        @(negedge clk);
        while (led(cab) !== 1'b0) @(negedge clk);
        while (led(cab) !== 1'b1) @(negedge clk);
        foreach (ms[i]) begin
            if (ms[i] == 0) break;
            v = led(cab);
            n = 0;
            while (led(cab) === v) begin
                n++;
                @(negedge clk);
            end
            chk(n, ms[i] * CYC);
        end
        @(posedge clk);
    endtask : wave

    // ==========
    // Scenarios.
    task automatic t_regs;
        rd(wsc_pkg::REG_CTRL, OK);
        chk(d, wsc_pkg::CTRL_RESET);
        wr(wsc_pkg::REG_CTRL, 32'h0, OK);
        rd(wsc_pkg::REG_CTRL, OK);
        chk(d, 32'h0);
        wr(wsc_pkg::REG_CTRL, 32'h1, OK);
        rd(4'h8, ERR);
        chk(d, 32'h0);
        wr(4'hC, 32'hFFFF_FFFF, ERR);
        rd(wsc_pkg::REG_CTRL, OK);
        chk(d, 32'h1);
        st(3'h0, 3'h0);
    endtask : t_regs

    task automatic t_couple;
        powered <= 1'b1;
        cyc(200);
        st(3'h0, 3'h0);
        sys(3'h3, 1'b0, 1'b0);
        token <= 1'b1;
        wave(1'b0, 100, 100, 100, 0);
        st(3'h1, 3'h1);
        press(1'b1);
        st(3'h1, 3'h1);
        press(1'b0);
        wave(1'b0, 500, 500, 0, 0);
        st(3'h2, 3'h2);
        radio <= 1'b1;
        cyc(10);
        sys(3'h1, 1'b1, 1'b1);
        st(3'h6, 3'h4);
        en <= 1'b1;
        cyc(4);
        chk(c_en, 1'b1);
        en <= 1'b0;
    endtask : t_couple

    task automatic t_loss;
        radio <= 1'b0;
        cyc(SAFE * CYC - 15);
        sys(3'h1, 1'b1, 1'b0);
        chk(c_led, 1'b1);
        cyc(40);
        sys(3'h3, 1'b0, 1'b0);
        st(3'h7, 3'h2);
        radio <= 1'b1;
        cyc(10);
        sys(3'h1, 1'b1, 1'b1);
    endtask : t_loss

    task automatic t_emerg;
        power_on_self_test_ok <= 1'b0;
        wave(1'b1, 200, 200, 200, 400);
        sys(3'h2, 1'b0, 1'b0);
        power_on_self_test_ok <= 1'b1;
        cyc(20);
        sys(3'h1, 1'b1, 1'b1);
    endtask : t_emerg

    task automatic t_power;
        powered <= 1'b0;
        cyc(SAFE * CYC + 30);
        sys(3'h3, 1'b0, 1'b0);
        st(3'h0, 3'h0);
        powered <= 1'b1;
        cyc(5);
        couple();
    endtask : t_power

    task automatic t_dyn;
        token <= 1'b0;
        cyc(SAFE * CYC + 30);
        tok_cab <= 1'b1;
        cyc(5);
        sys(3'h0, 1'b1, 1'b0);
        tok_cab <= 1'b0;
        token <= 1'b1;
        saw_safe = 1'b0;
        cyc(5);
        couple();
        chk(saw_safe, 1'b0);
        token <= 1'b0;
        cyc(SAFE * CYC + 30);
        tok_cab <= 1'b1;
        cyc(5);
        tok_cab <= 1'b0;
        {token, radio} <= 2'b10;
        cyc(5);
        press(1'b0);
        cyc(COUPLE * CYC - 57);
        sys(3'h0, 1'b1, 1'b0);
        st(3'h2, 3'h2);
        cyc(80);
        sys(3'h3, 1'b0, 1'b0);
        st(3'h5, 3'h1);
        {token, radio} <= 2'b01;
        cyc(5);
        token <= 1'b1;
        cyc(5);
        couple();
    endtask : t_dyn

    // ==========
    // Clock, watchdog and main sequence.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(negedge clk) begin
        if (c_state === 3'h3) saw_safe = 1'b1;
    end

    always @(posedge clk) begin
        ticks++;
        if (ticks == 100000) begin
            failures++;
            end_sim();
        end
    end

    initial begin
        {rstn, powered, token, stop, en, radio, tok_cab, saw_safe} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wstrb, wdata} = '0;
        power_on_self_test_ok = 1'b1;
        cyc(5);
        rstn <= 1'b1;
        cyc(2);
        t_regs();
        t_couple();
        t_loss();
        t_emerg();
        t_power();
        t_dyn();
        end_sim();
    end
endmodule : tb_wireless_safety_coupling_fsm
